/* File: hdl/dpme_defs.vh */
`ifndef DPME_DEFS_VH
`define DPME_DEFS_VH

// ==========================================================
// register word indices (address port is 5 bits)
`define DPME_ADDR_W        5
`define DPME_A_CTRL        5'h00
`define DPME_A_PERIOD      5'h01
`define DPME_A_EVENT1      5'h02
`define DPME_A_EVENT2      5'h03
`define DPME_A_EVENT3      5'h04
`define DPME_A_EVENT4      5'h05
`define DPME_A_CYC_ADJ_A   5'h06
`define DPME_A_CYC_ADJ_B   5'h07
`define DPME_A_ADAPT_OFS   5'h08
`define DPME_A_PHASE       5'h09
`define DPME_A_SAMP1       5'h0a
`define DPME_A_SAMP2       5'h0b
`define DPME_A_BLK_A_BEG   5'h0c
`define DPME_A_BLK_A_END   5'h0d
`define DPME_A_BLK_B_BEG   5'h0e
`define DPME_A_BLK_B_END   5'h0f
`define DPME_A_STATUS      5'h10
`define DPME_A_COUNT       5'h11

// ==========================================================
// control register fields
`define DPME_CTRL_EN       0
`define DPME_CTRL_MODE_LO  1
`define DPME_CTRL_MODE_HI  2
`define DPME_CTRL_PH_SEL   3
`define DPME_CTRL_ADPT_SEL 4

// ==========================================================
// mode encodings and reset values
`define DPME_MODE_NORMAL   2'h0
`define DPME_MODE_MULTI    2'h1
`define DPME_MODE_RESON    2'h2
`define DPME_RST_CTRL      16'h0000
`define DPME_RST_PERIOD    16'h00ff
`define DPME_RST_EVENT     16'h0000

`endif

/* File: hdl/dpme_edge_out.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// set/clear level driven by counter matches
module dpme_edge_out
(
  input  wire        mclk,     // system clock
  input  wire        rst_b,    // async reset, active low
  input  wire        run,      // counter running
  input  wire [15:0] cnt,      // period counter
  input  wire [15:0] set_at,   // rise target
  input  wire [15:0] clr_at,   // fall target
  input  wire        force_hi, // full-width pulse
  output reg         level_r   // output level
);

  // clear beats set so an equal pair gives zero width
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      level_r <= 1'b0;
    else if (!run)
      level_r <= 1'b0;
    else if (force_hi)
      level_r <= 1'b1;
    else if (cnt == clr_at)
      level_r <= 1'b0;
    else if (cnt == set_at)
      level_r <= 1'b1;
  end

endmodule
`default_nettype wire

/* File: hdl/dpme_engine.v */
`timescale 1ns/1ps
`default_nettype none
`include "dpme_defs.vh"
// ==========================================================
// edge placement engine for one digital_pulse_module
module dpme_engine
(
  input  wire        mclk,           // 40 MHz system clock
  input  wire        rst_b,          // async reset, active low
  input  wire [4:0]  addr,           // register word index
  input  wire [15:0] wdata,          // write data
  input  wire        wr,             // write strobe
  input  wire        rd,             // read strobe
  output reg  [15:0] rdata,          // read data, cycle after rd
  input  wire [15:0] filt_duty,      // filter duty output
  input  wire [15:0] filt_period,    // filter period output
  output wire        pulse_output_a, // gate drive A
  output wire        pulse_output_b, // gate drive B
  output wire        adapt_trig,     // adaptive sample trigger
  output wire        samp_trig_1,    // sample trigger 1
  output wire        samp_trig_2,    // sample trigger 2
  output wire        blank_a,        // blanking window A
  output wire        blank_b,        // blanking window B
  output wire        phase_trig,     // phase trigger to next module
  output reg         period_start    // pulse at counter restart
);

  // ==========================================================
  // programmable registers
  reg  [15:0] ctrl_r;
  reg  [15:0] period_limit_r;
  reg  [15:0] event1_r;
  reg  [15:0] event2_r;
  reg  [15:0] event3_r;
  reg  [15:0] event4_r;
  reg  [15:0] cyc_adj_a_r;
  reg  [15:0] cyc_adj_b_r;
  reg  [15:0] adapt_ofs_r;
  reg  [15:0] phase_r;
  reg  [15:0] samp1_r;
  reg  [15:0] samp2_r;
  reg  [15:0] blk_a_beg_r;
  reg  [15:0] blk_a_end_r;
  reg  [15:0] blk_b_beg_r;
  reg  [15:0] blk_b_end_r;

  // ==========================================================
  // engine state
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;
  reg  [1:0]  mode_r;
  reg  [15:0] rdata_nxt;
  wire        run      = ctrl_r[`DPME_CTRL_EN];
  wire [1:0]  mode_req = ctrl_r[`DPME_CTRL_MODE_HI:`DPME_CTRL_MODE_LO];
  wire        wrap_pt  = (cnt_r >= period_limit_r);

  // ==========================================================
  // arithmetic helpers, 19 bits with bit 18 as sign
  function [18:0] ext;
    input [15:0] v;
    begin
      ext = {3'h0, v};
    end
  endfunction

  // clamp into [0, limit]; a pulse that cannot cross the end stops there
  function [15:0] fit_sat;
    input [18:0] x;
    input [15:0] lim;
    begin
      if (x[18])
        fit_sat = 16'h0000;
      else if (x > ext(lim))
        fit_sat = lim;
      else
        fit_sat = x[15:0];
    end
  endfunction

  // fold one period either way so the edge lands inside [0, limit]
  function [15:0] fit_wrap;
    input [18:0] x;
    input [15:0] lim;
    reg   [18:0] len;
    reg   [18:0] y;
    begin
      len = ext(lim) + 19'h00001;
      y   = x;
      if (x[18])
        y = x + len;
      else if (x > ext(lim))
        y = x - len;
      fit_wrap = fit_sat(y, lim);
    end
  endfunction

  // ==========================================================
  // register writes; mode only moves to the engine at wrap or while stopped
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r         <= `DPME_RST_CTRL;
      period_limit_r <= `DPME_RST_PERIOD;
      event1_r       <= `DPME_RST_EVENT;
      event2_r       <= `DPME_RST_EVENT;
      event3_r       <= `DPME_RST_EVENT;
      event4_r       <= `DPME_RST_EVENT;
      cyc_adj_a_r    <= `DPME_RST_EVENT;
      cyc_adj_b_r    <= `DPME_RST_EVENT;
      adapt_ofs_r    <= `DPME_RST_EVENT;
      phase_r        <= `DPME_RST_EVENT;
      samp1_r        <= `DPME_RST_EVENT;
      samp2_r        <= `DPME_RST_EVENT;
      blk_a_beg_r    <= `DPME_RST_EVENT;
      blk_a_end_r    <= `DPME_RST_EVENT;
      blk_b_beg_r    <= `DPME_RST_EVENT;
      blk_b_end_r    <= `DPME_RST_EVENT;
    end
    else if (wr)
    begin
      case (addr)
        `DPME_A_CTRL:      ctrl_r         <= wdata;
        `DPME_A_PERIOD:    period_limit_r <= wdata;
        `DPME_A_EVENT1:    event1_r       <= wdata;
        `DPME_A_EVENT2:    event2_r       <= wdata;
        `DPME_A_EVENT3:    event3_r       <= wdata;
        `DPME_A_EVENT4:    event4_r       <= wdata;
        `DPME_A_CYC_ADJ_A: cyc_adj_a_r    <= wdata;
        `DPME_A_CYC_ADJ_B: cyc_adj_b_r    <= wdata;
        `DPME_A_ADAPT_OFS: adapt_ofs_r    <= wdata;
        `DPME_A_PHASE:     phase_r        <= wdata;
        `DPME_A_SAMP1:     samp1_r        <= wdata;
        `DPME_A_SAMP2:     samp2_r        <= wdata;
        `DPME_A_BLK_A_BEG: blk_a_beg_r    <= wdata;
        `DPME_A_BLK_A_END: blk_a_end_r    <= wdata;
        `DPME_A_BLK_B_BEG: blk_b_beg_r    <= wdata;
        `DPME_A_BLK_B_END: blk_b_end_r    <= wdata;
        default:           ctrl_r         <= ctrl_r;
      endcase
    end
  end

  // ==========================================================
  // period counter
  always @*
  begin
    if (!run)
      cnt_nxt = 16'h0000;
    else if (wrap_pt)
      cnt_nxt = 16'h0000;
    else
      cnt_nxt = cnt_r + 16'h0001;
  end

  // mode switches only at a boundary or while stopped so no period mixes equations
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r        <= 16'h0000;
      mode_r       <= `DPME_MODE_NORMAL;
      period_start <= 1'b0;
    end
    else
    begin
      cnt_r        <= cnt_nxt;
      period_start <= run && wrap_pt;
      if (!run || wrap_pt)
        mode_r <= mode_req;
    end
  end

  // ==========================================================
  // shared terms of the edge equations, 19-bit two's complement
  wire [18:0] a_fall_raw = ext(event1_r) + ext(filt_duty)
                           + ext(cyc_adj_a_r);
  wire [18:0] dt1        = ext(event3_r) - ext(event2_r);
  wire [18:0] dt2        = ext(event1_r) + ext(period_limit_r)
                           - ext(event4_r);
  wire [18:0] dt_sum     = dt1 + dt2;
  // arithmetic halving keeps a negative sum negative
  wire [18:0] avg_dt     = {dt_sum[18], dt_sum[18:1]};
  wire [18:0] r_fall_raw = ext(event1_r) + ext(filt_duty) - avg_dt;
  wire [18:0] b_multi_w  = ext(filt_duty) + ext(cyc_adj_b_r);
  wire [18:0] duty_term  = ctrl_r[`DPME_CTRL_ADPT_SEL] ?
                           ext({1'b0, filt_duty[15:1]}) : ext(filt_duty);
  wire [18:0] adapt_raw  = ext(event1_r) + duty_term
                           + ext(adapt_ofs_r);

  // ==========================================================
  // per-mode targets for A and B
  reg  [15:0] a_rise;
  reg  [15:0] a_fall;
  reg  [15:0] b_rise;
  reg  [15:0] b_fall;
  reg         b_full;

  always @*
  begin
    a_rise = event1_r;
    a_fall = fit_sat(a_fall_raw, period_limit_r);
    b_rise = 16'h0000;
    b_fall = 16'h0000;
    b_full = 1'b0;
    case (mode_r)
      `DPME_MODE_NORMAL:
      begin
        // cycle adjust B is not an input here
        b_rise = fit_wrap(a_fall_raw + dt1, period_limit_r);
        b_fall = event4_r;
      end
      `DPME_MODE_MULTI:
      begin
        // events 2 and 4 never enter this branch
        b_rise = event3_r;
        b_fall = fit_wrap(ext(event3_r) + b_multi_w,
                          period_limit_r);
        b_full = !b_multi_w[18] &&
                 (b_multi_w > ext(period_limit_r));
      end
      `DPME_MODE_RESON:
      begin
        a_fall = fit_sat(r_fall_raw, period_limit_r);
        b_rise = fit_wrap(r_fall_raw + dt1, period_limit_r);
        b_fall = fit_wrap(ext(filt_period) - ext(period_limit_r)
                          + ext(event4_r), period_limit_r);
      end
      default: b_full = 1'b0; // mode 3: equal zero targets hold B low
    endcase
  end

  // ==========================================================
  // generated waveforms
  dpme_edge_out u_out_a
  (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .run      (run),
    .cnt      (cnt_r),
    .set_at   (a_rise),
    .clr_at   (a_fall),
    .force_hi (1'b0),
    .level_r  (pulse_output_a)
  );

  dpme_edge_out u_out_b
  (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .run      (run),
    .cnt      (cnt_r),
    .set_at   (b_rise),
    .clr_at   (b_fall),
    .force_hi (b_full),
    .level_r  (pulse_output_b)
  );

  // blanking windows take registers as they are in every mode
  dpme_edge_out u_blank_a
  (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .run      (run),
    .cnt      (cnt_r),
    .set_at   (blk_a_beg_r),
    .clr_at   (blk_a_end_r),
    .force_hi (1'b0),
    .level_r  (blank_a)
  );

  dpme_edge_out u_blank_b
  (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .run      (run),
    .cnt      (cnt_r),
    .set_at   (blk_b_beg_r),
    .clr_at   (blk_b_end_r),
    .force_hi (1'b0),
    .level_r  (blank_b)
  );

  // ==========================================================
  // triggers
  dpme_trig_out u_adapt
  (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .run     (run),
    .cnt     (cnt_r),
    .at      (fit_wrap(adapt_raw, period_limit_r)),
    .pulse_r (adapt_trig)
  );

  dpme_trig_out u_samp1
  (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .run     (run),
    .cnt     (cnt_r),
    .at      (samp1_r),
    .pulse_r (samp_trig_1)
  );

  dpme_trig_out u_samp2
  (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .run     (run),
    .cnt     (cnt_r),
    .at      (samp2_r),
    .pulse_r (samp_trig_2)
  );

  // live duty lets the filter steer phase between modules
  dpme_trig_out u_phase
  (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .run     (run),
    .cnt     (cnt_r),
    .at      (ctrl_r[`DPME_CTRL_PH_SEL] ? filt_duty : phase_r),
    .pulse_r (phase_trig)
  );

  // ==========================================================
  // read mux; unmapped words read zero
  always @*
  begin
    case (addr)
      `DPME_A_CTRL:      rdata_nxt = ctrl_r;
      `DPME_A_PERIOD:    rdata_nxt = period_limit_r;
      `DPME_A_EVENT1:    rdata_nxt = event1_r;
      `DPME_A_EVENT2:    rdata_nxt = event2_r;
      `DPME_A_EVENT3:    rdata_nxt = event3_r;
      `DPME_A_EVENT4:    rdata_nxt = event4_r;
      `DPME_A_CYC_ADJ_A: rdata_nxt = cyc_adj_a_r;
      `DPME_A_CYC_ADJ_B: rdata_nxt = cyc_adj_b_r;
      `DPME_A_ADAPT_OFS: rdata_nxt = adapt_ofs_r;
      `DPME_A_PHASE:     rdata_nxt = phase_r;
      `DPME_A_SAMP1:     rdata_nxt = samp1_r;
      `DPME_A_SAMP2:     rdata_nxt = samp2_r;
      `DPME_A_BLK_A_BEG: rdata_nxt = blk_a_beg_r;
      `DPME_A_BLK_A_END: rdata_nxt = blk_a_end_r;
      `DPME_A_BLK_B_BEG: rdata_nxt = blk_b_beg_r;
      `DPME_A_BLK_B_END: rdata_nxt = blk_b_end_r;
      `DPME_A_STATUS:    rdata_nxt = {10'h000, pulse_output_b, pulse_output_a,
                                      b_full, mode_r, run};
      `DPME_A_COUNT:     rdata_nxt = cnt_r;
      default:           rdata_nxt = 16'h0000;
    endcase
  end

  // data only valid the cycle after rd; zero otherwise
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rdata <= 16'h0000;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= 16'h0000;
  end

endmodule
`default_nettype wire

/* File: hdl/dpme_trig_out.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one-cycle pulse when counter meets target
module dpme_trig_out
(
  input  wire        mclk,   // system clock
  input  wire        rst_b,  // async reset, active low
  input  wire        run,    // counter running
  input  wire [15:0] cnt,    // period counter
  input  wire [15:0] at,     // trigger target
  output reg         pulse_r // trigger pulse
);

  // registered compare keeps the output glitch free
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pulse_r <= 1'b0;
    else
      pulse_r <= run && (cnt == at);
  end

endmodule
`default_nettype wire

/* File: tb/dpme_filt_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// loop filter stand-in: holds the duty and period it is told
module dpme_filt_model
(
  input  wire logic        mclk,       // clock
  input  wire logic        rst_b,      // reset, active low
  input  wire logic [15:0] duty_set,   // next duty
  input  wire logic [15:0] period_set, // next period
  output logic      [15:0] duty_r,     // duty to engine
  output logic      [15:0] period_r    // period to engine
);
  // outputs move only after an edge, like a real filter update
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      duty_r   <= 16'h0000;
      period_r <= 16'h0000;
    end
    else
    begin
      duty_r   <= duty_set;
      period_r <= period_set;
    end
  end
endmodule
`default_nettype wire

/* File: tb/dpme_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpme_defs.vh"
// ==========================================================
// port checks for the edge engine
module dpme_props
(
  input wire logic        mclk,           // clock
  input wire logic        rst_b,          // reset
  input wire logic [4:0]  addr,           // index
  input wire logic [15:0] wdata,          // data in
  input wire logic        wr,             // write
  input wire logic        rd,             // read
  input wire logic [15:0] rdata,          // data out
  input wire logic [15:0] filt_duty,      // duty
  input wire logic [15:0] filt_period,    // period
  input wire logic        pulse_output_a, // gate a
  input wire logic        pulse_output_b, // gate b
  input wire logic        adapt_trig,     // adaptive
  input wire logic        samp_trig_1,    // sample 1
  input wire logic        samp_trig_2,    // sample 2
  input wire logic        blank_a,        // blank a
  input wire logic        blank_b,        // blank b
  input wire logic        phase_trig,     // phase
  input wire logic        period_start    // restart
);
  logic [15:0] ctrl_r, lim_r, e1_r, e3_r, e4_r, s1_r, ph_r;
  logic [16:0] cm_r;   // cycles since restart
  logic [16:0] cnow;   // present counter value
  logic [1:0]  mact_r; // equations in force
  logic        sync_r; // counter position known

  function automatic logic [16:0] nx(input logic [15:0] v);
    nx = (v >= lim_r) ? 17'h00000 : {1'b0, v} + 17'h00001;
  endfunction

  assign cnow = period_start ? 17'h00000 : cm_r;

  // ==========================================================
  // shadow settings; position only trusted after a restart
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_r <= `DPME_RST_CTRL;
      lim_r  <= `DPME_RST_PERIOD;
      e1_r   <= `DPME_RST_EVENT;
      e3_r   <= `DPME_RST_EVENT;
      e4_r   <= `DPME_RST_EVENT;
      s1_r   <= 16'h0000;
      ph_r   <= 16'h0000;
      cm_r   <= 17'h00000;
      mact_r <= `DPME_MODE_NORMAL;
      sync_r <= 1'b0;
    end
    else
    begin
      if (wr)
      begin
        case (addr)
          `DPME_A_CTRL:   ctrl_r <= wdata;
          `DPME_A_PERIOD: lim_r <= wdata;
          `DPME_A_EVENT1: e1_r <= wdata;
          `DPME_A_EVENT3: e3_r <= wdata;
          `DPME_A_EVENT4: e4_r <= wdata;
          `DPME_A_SAMP1:  s1_r <= wdata;
          `DPME_A_PHASE:  ph_r <= wdata;
          default:        ;
        endcase
      end
      cm_r   <= period_start ? 17'h00001 : cm_r + 17'h00001;
      mact_r <= period_start ? ctrl_r[2:1] : mact_r;
      sync_r <= ctrl_r[0] & (sync_r | period_start);
    end
  end

  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // edge placement, period length, trigger width and idle gates
  property p_gap;
    period_start && sync_r |-> cm_r == {1'b0, lim_r} + 17'h00001;
  endproperty
  a_gap: assert property (p_gap) else $error("bad period");
  property p_arise;
    $rose(pulse_output_a) && sync_r |-> cnow == nx(e1_r);
  endproperty
  a_arise: assert property (p_arise) else $error("a rise");
  property p_bfall;
    $fell(pulse_output_b) && sync_r && mact_r == `DPME_MODE_NORMAL
      |-> cnow == nx(e4_r);
  endproperty
  a_bfall: assert property (p_bfall) else $error("b fall");
  property p_brise;
    $rose(pulse_output_b) && sync_r && mact_r == `DPME_MODE_MULTI
      |-> cnow == nx(e3_r);
  endproperty
  a_brise: assert property (p_brise) else $error("b rise");
  property p_samp;
    samp_trig_1 && sync_r |-> cnow == nx(s1_r);
  endproperty
  a_samp: assert property (p_samp) else $error("sample 1");
  property p_pulse;
    samp_trig_1 |=> !samp_trig_1;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long pulse");
  property p_phase;
    phase_trig && sync_r && !ctrl_r[3] |-> cnow == nx(ph_r);
  endproperty
  a_phase: assert property (p_phase) else $error("phase");
  property p_off;
    (!ctrl_r[0]) [*3] |-> !pulse_output_a && !pulse_output_b;
  endproperty
  a_off: assert property (p_off) else $error("gate on idle");

  c_multi: cover property (mact_r == `DPME_MODE_MULTI && period_start);
  c_reson: cover property (mact_r == `DPME_MODE_RESON && period_start);
  c_phase: cover property (phase_trig && ctrl_r[3]);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpme_defs.vh"
// ==========================================================
// self-checking bench for the edge engine
module tb;
  localparam logic [15:0] LIM = 16'h0063; // 100-cycle period
  logic        mclk, rst_b, wr, rd, pa, pb, adt, s1t, s2t;
  logic        bka, bkb, pht, pst, pa_q, pb_q, ba_q, bb_q;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, fd, fp, dset, pset, got, tc_m, tnow, t;
  logic [15:0] obs [13];
  logic [15:0] cfg [15];
  logic [15:0] rows [7][13];
  int          errors, checks_done;

  dpme_engine dpme_engine_i
  (
    .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .filt_duty(fd), .filt_period(fp),
    .pulse_output_a(pa), .pulse_output_b(pb), .adapt_trig(adt),
    .samp_trig_1(s1t), .samp_trig_2(s2t), .blank_a(bka),
    .blank_b(bkb), .phase_trig(pht), .period_start(pst)
  );
  dpme_filt_model dpme_filt_model_i
  (
    .mclk(mclk), .rst_b(rst_b), .duty_set(dset), .period_set(pset),
    .duty_r(fd), .period_r(fp)
  );

  always #12.5 mclk = ~mclk;

  // previous levels and our own copy of the counter position
  always @(posedge mclk)
  begin
    pa_q <= pa;
    pb_q <= pb;
    ba_q <= bka;
    bb_q <= bkb;
    tc_m <= pst ? 16'h0001 : tc_m + 16'h0001;
  end
  assign tnow = pst ? 16'h0000 : tc_m;

  function automatic logic [15:0] outs();
    outs = {7'h00, pa, pb, adt, s1t, s2t, bka, bkb, pht, pst};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("errors %0d, checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // bounded wait for the restart pulse
  task automatic wait_ps();
    int n;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (pst !== 1'b1 && n < 300);
    check({15'h0000, pst}, 16'h0001);
  endtask

  // ==========================================================
  // record the target of every edge over one settled period
  task automatic scan();
    for (int j = 0; j < 13; j++)
      obs[j] = 16'hffff;
    obs[4] = 16'h0000;
    wait_ps();
    wait_ps();
    repeat (LIM + 1)
    begin
      t = (tnow == 16'h0000) ? LIM : tnow - 16'h0001;
      if (pa && !pa_q) obs[0] = t;
      if (!pa && pa_q) obs[1] = t;
      if (pb && !pb_q) obs[2] = t;
      if (!pb && pb_q) obs[3] = t;
      if (pb) obs[4] = obs[4] + 16'h0001;
      if (adt) obs[5] = t;
      if (pht) obs[6] = t;
      if (s1t) obs[7] = t;
      if (s2t) obs[8] = t;
      if (bka && !ba_q) obs[9] = t;
      if (!bka && ba_q) obs[10] = t;
      if (bkb && !bb_q) obs[11] = t;
      if (!bkb && bb_q) obs[12] = t;
      @(posedge mclk);
      #1;
    end
    check({15'h0000, pst}, 16'h0001);
  endtask

  task automatic run_row(input int r);
    wreg(`DPME_A_CTRL, 16'h0000);
    wreg(`DPME_A_EVENT2, rows[r][1]);
    wreg(`DPME_A_EVENT3, rows[r][2]);
    wreg(`DPME_A_EVENT4, rows[r][3]);
    wreg(`DPME_A_CYC_ADJ_B, rows[r][4]);
    dset <= rows[r][5];
    pset <= rows[r][6];
    wreg(`DPME_A_CTRL, rows[r][0] | 16'h0001);
    scan();
    check(obs[0], cfg[1]);
    check(obs[1], rows[r][7]);
    check(obs[2], rows[r][8]);
    check(obs[3], rows[r][9]);
    check(obs[4], rows[r][10]);
    check(obs[5], rows[r][11]);
    check(obs[6], rows[r][12]);
    for (int j = 7; j < 13; j++)
      check(obs[j], cfg[j + 2]);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    int n;
    mclk = 1'b0;
    rst_b = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 5'h00;
    wdata = 16'h0000;
    dset = 16'h0000;
    pset = 16'h0000;
    errors = 0;
    checks_done = 0;
    cfg = '{LIM, 16'h000a, 16'h0032, 16'h0037, 16'h005f, 16'h0002,
      16'h0007, 16'h0003, 16'h0014, 16'h0005, 16'h0046, 16'h000c,
      16'h0014, 16'h003c, 16'h0041};
    // ctrl e2 e3 e4 adjb duty fper | a_dn b_up b_dn b_width adapt phase
    rows = '{
      '{16'h0000, 16'h0032, 16'h0037, 16'h005f, 16'h0007, 16'h001e, 16'h0000,
        16'h002a, 16'h002f, 16'h005f, 16'h0030, 16'h002b, 16'h0014},
      '{16'h0018, 16'h0032, 16'h0037, 16'h005f, 16'h0014, 16'h001e, 16'h0000,
        16'h002a, 16'h002f, 16'h005f, 16'h0030, 16'h001c, 16'h001e},
      '{16'h0002, 16'h0003, 16'h0037, 16'h0007, 16'h0007, 16'h001e, 16'h0000,
        16'h002a, 16'h0037, 16'h005c, 16'h0025, 16'h002b, 16'h0014},
      '{16'h0002, 16'h0003, 16'h0050, 16'h0007, 16'h0007, 16'h001e, 16'h0000,
        16'h002a, 16'h0050, 16'h0011, 16'h0025, 16'h002b, 16'h0014},
      '{16'h0004, 16'h0032, 16'h0037, 16'h005f, 16'h0007, 16'h0028, 16'h0050,
        16'h0029, 16'h002e, 16'h004c, 16'h001e, 16'h0035, 16'h0014},
      '{16'h0002, 16'h0003, 16'h0037, 16'h0007, 16'h0007, 16'h005f, 16'h0000,
        16'h0063, 16'hffff, 16'hffff, 16'h0064, 16'h0008, 16'h0014},
      // resonant with a negative dead-time sum
      '{16'h0004, 16'h0046, 16'h0032, 16'h0063, 16'h0007, 16'h0028, 16'h0050,
        16'h0037, 16'h0023, 16'h0050, 16'h002d, 16'h0035, 16'h0014}};
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    #1;
    check(outs(), 16'h0000);
    rreg(`DPME_A_CTRL, got);
    check(got, `DPME_RST_CTRL);
    rreg(`DPME_A_PERIOD, got);
    check(got, `DPME_RST_PERIOD);
    rreg(5'h1f, got);
    check(got, 16'h0000);
    wreg(`DPME_A_STATUS, 16'hffff);
    rreg(`DPME_A_STATUS, got);
    check(got, 16'h0000);
    rreg(`DPME_A_COUNT, got);
    check(got, 16'h0000);
    for (int i = 0; i < 15; i++)
      wreg(5'(i + 1), cfg[i]);
    rreg(`DPME_A_EVENT1, got);
    check(got, cfg[1]);
    for (int r = 0; r < 7; r++)
      run_row(r);
    // mode written mid-period must wait for the restart
    run_row(0);
    wait_ps();
    repeat (30) @(posedge mclk);
    wreg(`DPME_A_CTRL, 16'h0003);
    #1;
    n = 0;
    while (!(pb && !pb_q) && n < 100)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(tnow - 16'h0001, cfg[3] - cfg[2] + 16'h002a);
    scan();
    check(obs[2], cfg[3]);
    // reset in mid-run
    @(posedge mclk);
    rst_b <= 1'b0;
    #1;
    check(outs(), 16'h0000);
    @(posedge mclk);
    rst_b <= 1'b1;
    rreg(`DPME_A_CTRL, got);
    check(got, `DPME_RST_CTRL);
    conclude();
  end

  // hang guard, about three times the expected run
  initial
  begin
    #250000;
    errors++;
    conclude();
  end
endmodule

bind dpme_engine dpme_props dpme_props_i
(
  .mclk(mclk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .filt_duty(filt_duty),
  .filt_period(filt_period), .pulse_output_a(pulse_output_a),
  .pulse_output_b(pulse_output_b), .adapt_trig(adapt_trig),
  .samp_trig_1(samp_trig_1), .samp_trig_2(samp_trig_2),
  .blank_a(blank_a), .blank_b(blank_b), .phase_trig(phase_trig),
  .period_start(period_start)
);
`default_nettype wire
